/* File: design/dpsb_prefetch.sv */
/*
  data prefetch stream buffer: eight streams of two 64-byte halves each, look-ahead
  and half-line re-fetch, generation-tagged fetches so a superseded fetch is stale.
  assumes the memory side returns the slot and generation it was handed, and that
  one demand request arrives per cycle at most.
*/
`timescale 1ns/10ps

module dpsb_prefetch
  import dpsb_pkg::*;
#(
  parameter int GEN_W = GEN_W_DEF
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_FROM_L2,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic L2_ACTIVE,
  output logic RSP_VALID,
  output logic RSP_HIT,
  output logic RSP_LINE,
  output logic RSP_MISS,
  output logic [LINE_BITS-1:0] RSP_DATA,
  output logic FETCH_VALID,
  input wire logic FETCH_READY,
  output logic [ADDR_W-1:0] FETCH_ADDR,
  output logic [SLOT_W-1:0] FETCH_SLOT,
  output logic [GEN_W-1:0] FETCH_GEN,
  input wire logic RET_VALID,
  input wire logic RET_CANCELLED,
  input wire logic [SLOT_W-1:0] RET_SLOT,
  input wire logic [GEN_W-1:0] RET_GEN,
  input wire logic [HALF_BITS-1:0] RET_DATA,
  output logic RET_STALE,
  input wire logic ATTR_WR,
  input wire logic ATTR_SUPERVISOR,
  input wire logic [REGION_W-1:0] ATTR_IDX,
  input wire logic ATTR_PREFETCH_IN,
  output logic ATTR_RD_PREFETCH
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [HA_W-1:0] base_r [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] valid_r;
  logic [NUM_SLOTS-1:0] dv_r;
  logic [NUM_SLOTS-1:0] pend_r;
  logic [NUM_SLOTS-1:0] need_r;
  logic [GEN_W-1:0] gen_r [NUM_SLOTS];
  logic [HALF_BITS-1:0] data_r [NUM_SLOTS];
  logic [ENTRY_W-1:0] alloc_ptr_r;
  logic [HA_W-1:0] cand_r;
  logic cand_v_r;
  logic [NUM_REGIONS-1:0] region_prefetch_enable_r;

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  logic [HA_W-1:0] req_half;
  logic [HA_W-1:0] next_half;
  logic [NUM_ENTRIES-1:0] hit0;
  logic [NUM_ENTRIES-1:0] hit1;
  logic [NUM_ENTRIES-1:0] nxt_hit;
  logic hit_any;
  logic [ENTRY_W-1:0] hit_e;
  logic hit_hi;
  logic [SLOT_W-1:0] hit_slot;
  logic [SLOT_W-1:0] other_slot;
  logic [NUM_ENTRIES-1:0] e_dat;
  logic [NUM_SLOTS-1:0] wr_slots;
  logic hit_dat;

  assign req_half = REQ_ADDR[ADDR_W-1:HALF_OFS];
  assign next_half = req_half + HA_W'(1);

  genvar g;
  generate
    for (g = 0; g < NUM_ENTRIES; g++)
    begin : g_cmp
      assign hit0[g] = valid_r[g] && (base_r[g] == req_half);
      assign hit1[g] = valid_r[g] && ((base_r[g] + HA_W'(1)) == req_half);
      assign nxt_hit[g] = valid_r[g] && (base_r[g] == next_half);
      assign e_dat[g] = hit0[g] ? dv_r[2*g] : dv_r[2*g+1];
      assign wr_slots[2*g] = REQ_VALID && REQ_WRITE && hit0[g];
      assign wr_slots[2*g+1] = REQ_VALID && REQ_WRITE && hit1[g];
    end
  endgenerate

  always_comb
  begin
    hit_any = 1'b0;
    hit_e = '0;
    hit_hi = 1'b0;
    hit_dat = 1'b0;
    // a half held by two entries is served from the one that has its data
    for (int e = NUM_ENTRIES - 1; e >= 0; e--)
    begin
      if ((hit0[e] || hit1[e]) && (e_dat[e] || !hit_dat))
      begin
        hit_any = 1'b1;
        hit_dat = e_dat[e];
        hit_e = ENTRY_W'(e);
        hit_hi = !hit0[e];
      end
    end
  end

  // a level-1 access names one half only
  assign hit_slot = {hit_e, hit_hi};
  assign other_slot = {hit_e, !hit_hi};

  logic rd;
  logic wr;
  logic pf_en;
  logic l1_side;
  logic cand_hit;
  logic l1_hit_data;
  logic l2_hit;
  logic refetch_fire;
  logic alloc_fire;
  logic wr_hit;

  assign rd = REQ_VALID && !REQ_WRITE;
  assign wr = REQ_VALID && REQ_WRITE;
  assign pf_en = region_prefetch_enable_r[REQ_ADDR[REGION_LSB+REGION_W-1:REGION_LSB]];
  assign l1_side = !REQ_FROM_L2 || !L2_ACTIVE;
  assign cand_hit = cand_v_r && (cand_r == req_half);
  assign l1_hit_data = rd && l1_side && hit_any && dv_r[hit_slot];
  assign l2_hit = rd && !l1_side && hit_any && !hit_hi && dv_r[hit_slot] && dv_r[other_slot];
  assign refetch_fire = rd && l1_side && pf_en && hit_any && !dv_r[other_slot] && !pend_r[other_slot]
                        && !need_r[other_slot]
                        && !(FETCH_VALID && FETCH_SLOT == other_slot);
  assign alloc_fire = rd && pf_en && (hit_any || cand_hit) && !(|nxt_hit);
  assign wr_hit = wr && hit_any;

  // ----------------------------------------------------------------
  // fetch issue
  // ----------------------------------------------------------------
  logic fetch_fire;
  logic load;
  logic [SLOT_W-1:0] pick;
  logic ret_ok;

  assign fetch_fire = FETCH_VALID && FETCH_READY;
  assign load = (!FETCH_VALID || FETCH_READY) && (|need_r);
  assign ret_ok = RET_VALID && (RET_GEN == gen_r[RET_SLOT]) && pend_r[RET_SLOT];

  // lowest slot first, so an early half goes before its next half
  always_comb
  begin
    pick = '0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--)
    begin
      if (need_r[s])
      begin
        pick = SLOT_W'(s);
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      FETCH_VALID <= 1'b0;
      FETCH_ADDR <= '0;
      FETCH_SLOT <= '0;
      FETCH_GEN <= '0;
    end
    else if (!FETCH_VALID || FETCH_READY)
    begin
      FETCH_VALID <= |need_r;
      if (|need_r)
      begin
        FETCH_SLOT <= pick;
        FETCH_GEN <= gen_r[pick];
        FETCH_ADDR <= {base_r[pick[SLOT_W-1:1]] + HA_W'(pick[0]), HALF_OFS'(0)};
      end
    end
  end

  // ----------------------------------------------------------------
  // stream and slot status
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      valid_r <= '0;
      dv_r <= '0;
      pend_r <= '0;
      need_r <= '0;
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
        gen_r[s] <= '0;
      end
      for (int e = 0; e < NUM_ENTRIES; e++)
      begin
        base_r[e] <= '0;
      end
    end
    else
    begin
      // only a fetch of the current generation counts as outstanding
      if (fetch_fire && FETCH_GEN == gen_r[FETCH_SLOT])
      begin
        pend_r[FETCH_SLOT] <= 1'b1;
      end
      if (load)
      begin
        need_r[pick] <= 1'b0;
      end
      if (ret_ok)
      begin
        pend_r[RET_SLOT] <= 1'b0;
        dv_r[RET_SLOT] <= !RET_CANCELLED;
      end
      if (refetch_fire)
      begin
        need_r[other_slot] <= 1'b1;
      end
      // every slot naming the written half is dropped, a second copy too
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
        if (wr_slots[s])
        begin
          dv_r[s] <= 1'b0;
          pend_r[s] <= 1'b0;
          need_r[s] <= 1'b0;
          gen_r[s] <= gen_r[s] + GEN_W'(1);
        end
      end
      // generation bump retires any fetch in flight, whatever edge it leaves on
      if (alloc_fire)
      begin
        valid_r[alloc_ptr_r] <= 1'b1;
        base_r[alloc_ptr_r] <= next_half;
        for (int h = 0; h < 2; h++)
        begin
          dv_r[{alloc_ptr_r, 1'(h)}] <= 1'b0;
          pend_r[{alloc_ptr_r, 1'(h)}] <= 1'b0;
          need_r[{alloc_ptr_r, 1'(h)}] <= 1'b1;
          gen_r[{alloc_ptr_r, 1'(h)}] <= gen_r[{alloc_ptr_r, 1'(h)}] + GEN_W'(1);
        end
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (ret_ok && !RET_CANCELLED)
    begin
      data_r[RET_SLOT] <= RET_DATA;
    end
  end

  // entries fill in order, so once all eight are used the pointer names the oldest
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      alloc_ptr_r <= '0;
    end
    else if (alloc_fire)
    begin
      alloc_ptr_r <= alloc_ptr_r + ENTRY_W'(1);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cand_v_r <= 1'b0;
      cand_r <= '0;
    end
    else if (rd && pf_en && !hit_any)
    begin
      cand_v_r <= 1'b1;
      cand_r <= next_half;
    end
  end

  // ----------------------------------------------------------------
  // demand response
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      RSP_VALID <= 1'b0;
      RSP_HIT <= 1'b0;
      RSP_LINE <= 1'b0;
      RSP_MISS <= 1'b0;
      RSP_DATA <= '0;
      RET_STALE <= 1'b0;
    end
    else
    begin
      RSP_VALID <= rd;
      RSP_HIT <= l1_hit_data || l2_hit;
      RSP_LINE <= l2_hit;
      RSP_MISS <= rd && !(l1_hit_data || l2_hit);
      RSP_DATA <= l2_hit ? {data_r[other_slot], data_r[hit_slot]}
                  : l1_hit_data ? {HALF_BITS'(0), data_r[hit_slot]} : LINE_BITS'(0);
      RET_STALE <= RET_VALID && !ret_ok;
    end
  end

  // ----------------------------------------------------------------
  // memory attribute registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      region_prefetch_enable_r <= PREFETCH_RESET;
      ATTR_RD_PREFETCH <= 1'b0;
    end
    else
    begin
      if (ATTR_WR && ATTR_SUPERVISOR)
      begin
        region_prefetch_enable_r[ATTR_IDX] <= ATTR_PREFETCH_IN;
      end
      ATTR_RD_PREFETCH <= region_prefetch_enable_r[ATTR_IDX];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_no_double_pend: assert property (fetch_fire && FETCH_GEN == gen_r[FETCH_SLOT] |-> !pend_r[FETCH_SLOT])
    else $error("second live fetch for one slot");
  a_alloc_fetches: assert property (alloc_fire |=> need_r[{$past(alloc_ptr_r), 1'b0}]
    && need_r[{$past(alloc_ptr_r), 1'b1}] && valid_r[$past(alloc_ptr_r)])
    else $error("allocation did not queue both halves");
  a_stale_dropped: assert property (RET_VALID && RET_GEN != gen_r[RET_SLOT] && !dv_r[RET_SLOT]
    |=> !dv_r[$past(RET_SLOT)] ##0 RET_STALE)
    else $error("stale return filled a slot");
  a_cancel_nodata: assert property (ret_ok && RET_CANCELLED |=> !dv_r[$past(RET_SLOT)])
    else $error("cancelled return left data");
  a_hit_served: assert property (l1_hit_data && !REQ_FROM_L2 |=> RSP_VALID && RSP_HIT && !RSP_MISS)
    else $error("buffer hit not served");
  a_write_inval: assert property (wr_hit |=> !dv_r[$past(hit_slot)])
    else $error("write left prefetched data");
  a_l2_norefetch: assert property (rd && REQ_FROM_L2 && L2_ACTIVE |-> !refetch_fire)
    else $error("level-2 request caused re-fetch");
  a_l2_line: assert property (l2_hit |=> RSP_LINE && RSP_HIT)
    else $error("level-2 hit not whole line");
  a_region_off: assert property (REQ_VALID && !pf_en |-> !alloc_fire && !refetch_fire)
    else $error("prefetch in disabled region");
  a_attr_user: assert property (ATTR_WR && !ATTR_SUPERVISOR |=> $stable(region_prefetch_enable_r))
    else $error("user write changed attributes");
  a_ptr_oldest: assert property (alloc_fire |=> alloc_ptr_r == $past(alloc_ptr_r) + ENTRY_W'(1))
    else $error("allocation pointer did not advance");
  a_enable_reset: assert property (@(posedge CLK) disable iff (1'b0)
    RESET |=> region_prefetch_enable_r[PREFETCH_DEF_HI:PREFETCH_DEF_LO] == 4'hf)
    else $error("region enable reset wrong");

  c_alloc: cover property (alloc_fire);
  c_refetch: cover property (refetch_fire);
  c_stale: cover property (RET_STALE);
  c_l2_hit: cover property (l2_hit);

endmodule : dpsb_prefetch

/* File: pkg/dpsb_pkg.sv */
/*
  constants for the data prefetch stream buffer: line geometry, stream table size,
  attribute region map and reset values.
  assumes 32-bit byte addresses and one 16 MB attribute region per index.
*/
package dpsb_pkg;
  localparam int ADDR_W = 32;
  localparam int HALF_OFS = 6;
  localparam int HA_W = ADDR_W - HALF_OFS;
  localparam int LINE_BYTES = 128;
  localparam int HALF_BYTES = 64;
  localparam int HALF_BITS = HALF_BYTES * 8;
  localparam int LINE_BITS = LINE_BYTES * 8;
  localparam int NUM_ENTRIES = 8;
  localparam int ENTRY_W = 3;
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int GEN_W_DEF = 3;
  localparam int REGION_LSB = 24;
  localparam int REGION_W = 8;
  localparam int NUM_REGIONS = 256;
  localparam int PREFETCH_DEF_LO = 12;
  localparam int PREFETCH_DEF_HI = 15;
  localparam logic [NUM_REGIONS-1:0] PREFETCH_RESET = 256'hf000;
endpackage : dpsb_pkg

/* File: tb/dpsb_mem_model.sv */
/*
  memory side model: takes fetches with random stalls and answers each in order,
  one return every other cycle, with data or cancelled as the bench asks.
  assumes the block holds its fetch signals until ready is seen.
*/
`timescale 1ns/10ps
module dpsb_mem_model
  import dpsb_pkg::*;
#(
  parameter int GEN_W = GEN_W_DEF
)
(
  input wire logic CLK,
  input wire logic cancel_en,
  input wire logic FETCH_VALID,
  input wire logic [ADDR_W-1:0] FETCH_ADDR,
  input wire logic [SLOT_W-1:0] FETCH_SLOT,
  input wire logic [GEN_W-1:0] FETCH_GEN,
  output logic FETCH_READY,
  output logic RET_VALID,
  output logic RET_CANCELLED,
  output logic [SLOT_W-1:0] RET_SLOT,
  output logic [GEN_W-1:0] RET_GEN,
  output logic [HALF_BITS-1:0] RET_DATA
);
  logic [ADDR_W+SLOT_W+GEN_W-1:0] q[$];
  logic [ADDR_W+SLOT_W+GEN_W-1:0] h;
  logic took;
  int seed = 59549;
  initial
  begin
    FETCH_READY = 1'b0;
    RET_VALID = 1'b0;
    RET_CANCELLED = 1'b0;
    RET_SLOT = '0;
    RET_GEN = '0;
    RET_DATA = '0;
    forever
    begin
      @(posedge CLK);
      took = FETCH_VALID && FETCH_READY;
      h = {FETCH_ADDR, FETCH_SLOT, FETCH_GEN};
      #1;
      if (took)
        q.push_back(h);
      FETCH_READY = ($random(seed) & 3) != 0;
      // idle data lines never keep the last value
      RET_DATA = ~RET_DATA;
      if (q.size() > 0 && !RET_VALID)
      begin
        h = q.pop_front();
        RET_VALID = 1'b1;
        RET_CANCELLED = cancel_en;
        {RET_SLOT, RET_GEN} = h[SLOT_W+GEN_W-1:0];
        if (!cancel_en)
          RET_DATA = {16{h[ADDR_W+SLOT_W+GEN_W-1 -: ADDR_W]}};
      end
      else
        RET_VALID = 1'b0;
    end
  end
endmodule : dpsb_mem_model

/* File: tb/testbench.sv */
/*
  self-checking bench for the prefetch stream buffer: attribute bits, stream
  allocation and fetch order, line and half hits, write invalidate, cancelled returns.
  assumes the memory model in dpsb_mem_model; level-2 is active except in the last scenario.
*/
`timescale 1ns/10ps
module testbench
  import dpsb_pkg::*;
;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_FROM_L2 = 1'b0, cancel_en = 1'b0;
  logic ATTR_WR = 1'b0, ATTR_SUPERVISOR = 1'b0, ATTR_PREFETCH_IN = 1'b0;
  logic L2_ACTIVE = 1'b1;
  logic [ADDR_W-1:0] REQ_ADDR = '0;
  logic [REGION_W-1:0] ATTR_IDX = '0;
  logic RSP_VALID, RSP_HIT, RSP_LINE, RSP_MISS, FETCH_VALID, FETCH_READY;
  logic RET_VALID, RET_CANCELLED, RET_STALE, ATTR_RD_PREFETCH;
  logic [LINE_BITS-1:0] RSP_DATA;
  logic [ADDR_W-1:0] FETCH_ADDR;
  logic [SLOT_W-1:0] FETCH_SLOT, RET_SLOT;
  logic [GEN_W_DEF-1:0] FETCH_GEN, RET_GEN;
  logic [HALF_BITS-1:0] RET_DATA;
  logic [ADDR_W-1:0] fq[$];
  logic [SLOT_W-1:0] sq[$];
  logic [ADDR_W-1:0] a;
  int n_mismatch = 0;
  int check_count = 0;
  int n_stale = 0;
  int seed = 59549;

  always #5 CLK = ~CLK;

  dpsb_prefetch i_dut (.CLK(CLK), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_FROM_L2(REQ_FROM_L2), .REQ_ADDR(REQ_ADDR), .L2_ACTIVE(L2_ACTIVE), .RSP_VALID(RSP_VALID),
    .RSP_HIT(RSP_HIT), .RSP_LINE(RSP_LINE), .RSP_MISS(RSP_MISS), .RSP_DATA(RSP_DATA),
    .FETCH_VALID(FETCH_VALID), .FETCH_READY(FETCH_READY), .FETCH_ADDR(FETCH_ADDR),
    .FETCH_SLOT(FETCH_SLOT), .FETCH_GEN(FETCH_GEN), .RET_VALID(RET_VALID),
    .RET_CANCELLED(RET_CANCELLED), .RET_SLOT(RET_SLOT), .RET_GEN(RET_GEN), .RET_DATA(RET_DATA),
    .RET_STALE(RET_STALE), .ATTR_WR(ATTR_WR), .ATTR_SUPERVISOR(ATTR_SUPERVISOR),
    .ATTR_IDX(ATTR_IDX), .ATTR_PREFETCH_IN(ATTR_PREFETCH_IN), .ATTR_RD_PREFETCH(ATTR_RD_PREFETCH));

  dpsb_mem_model i_mem (.CLK(CLK), .cancel_en(cancel_en), .FETCH_VALID(FETCH_VALID),
    .FETCH_ADDR(FETCH_ADDR), .FETCH_SLOT(FETCH_SLOT), .FETCH_GEN(FETCH_GEN),
    .FETCH_READY(FETCH_READY), .RET_VALID(RET_VALID), .RET_CANCELLED(RET_CANCELLED),
    .RET_SLOT(RET_SLOT), .RET_GEN(RET_GEN), .RET_DATA(RET_DATA));

  always @(posedge CLK)
  begin
    if (FETCH_VALID && FETCH_READY)
    begin
      fq.push_back(FETCH_ADDR);
      sq.push_back(FETCH_SLOT);
    end
    if (RET_STALE)
      n_stale++;
  end

  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic chk_flag(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk_flag

  task automatic chk_addr(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_addr

  task automatic chk_data(input string nm, input logic [HALF_BITS-1:0] e, input logic [HALF_BITS-1:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_data

  task automatic close_out;
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  function automatic logic [HALF_BITS-1:0] pat(input logic [ADDR_W-1:0] x);
    return {16{x}};
  endfunction : pat

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick

  task automatic idle(input int n);
    REQ_VALID = 1'b0;
    tick(n);
  endtask : idle

  // request stays up so calls can run back to back; idle drops it
  task automatic req(input logic wr, input logic l2, input logic [ADDR_W-1:0] x);
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_FROM_L2 = l2;
    REQ_ADDR = x;
    tick(1);
    chk_flag("rsp_valid", !wr, RSP_VALID);
  endtask : req

  task automatic attr(input logic wr, input logic sup, input logic v, input logic e,
                      input logic [REGION_W-1:0] idx);
    ATTR_WR = wr;
    ATTR_SUPERVISOR = sup;
    ATTR_IDX = idx;
    ATTR_PREFETCH_IN = v;
    tick(1);
    ATTR_WR = 1'b0;
    tick(2);
    chk_flag("region_prefetch_enable", e, ATTR_RD_PREFETCH);
  endtask : attr

  // miss at x sets the candidate, x+64 hits it and opens a stream at x+128
  task automatic stream(input logic [ADDR_W-1:0] x, input logic pf);
    int k = 0;
    fq.delete();
    sq.delete();
    req(0, 0, x);
    chk_flag("miss", 1'b1, RSP_MISS);
    req(0, 0, x + 64);
    chk_flag("miss", 1'b1, RSP_MISS);
    idle(1);
    while (pf && fq.size() < 2 && k < 50)
    begin
      tick(1);
      k++;
    end
    if (pf && fq.size() < 2)
    begin
      n_mismatch++;
      close_out();
    end
    idle(12);
    if (pf)
    begin
      chk_addr("stream_first_fetch", x + 128, fq[0]);
      chk_addr("stream_second_fetch", x + 192, fq[1]);
      chk_flag("slot_pair", 1'b1, sq[1] == {sq[0][SLOT_W-1:1], 1'b1} && !sq[0][0]);
    end
    else
      chk_flag("no_fetch", 1'b1, fq.size() == 0);
  endtask : stream

  initial
  begin
    tick(8);
    RESET = 1'b0;
    attr(0, 0, 0, 1, 8'hc);
    attr(0, 0, 0, 1, 8'hf);
    attr(0, 0, 0, 0, 8'h10);
    attr(1, 0, 1, 0, 8'h1);
    attr(1, 1, 1, 1, 8'h1);
    attr(1, 1, 0, 0, 8'hd);
    attr(1, 1, 1, 1, 8'h2);
    for (int i = 0; i < 10; i++)
    begin
      a = 32'h01000000 | (i << 12) | ($random(seed) & 32'h0d80);
      stream(a, 1'b1);
      n_stale = 0;
      req(0, 1, a + 128);
      chk_flag("hit", 1'b1, RSP_HIT);
      chk_flag("line", 1'b1, RSP_LINE);
      chk_data("line_lo", pat(a + 128), RSP_DATA[HALF_BITS-1:0]);
      chk_data("line_hi", pat(a + 192), RSP_DATA[LINE_BITS-1:HALF_BITS]);
      req(0, 0, a + 192);
      chk_flag("hit", 1'b1, RSP_HIT);
      chk_flag("line", 1'b0, RSP_LINE);
      chk_data("half", pat(a + 192), RSP_DATA[HALF_BITS-1:0]);
      req(1, 0, a + 192);
      req(0, 0, a + 192);
      chk_flag("miss", 1'b1, RSP_MISS);
      req(0, 0, a + 128);
      chk_flag("hit", 1'b1, RSP_HIT);
      chk_data("half", pat(a + 128), RSP_DATA[HALF_BITS-1:0]);
      idle(30);
      chk_flag("stale", 1'b1, n_stale != 0);
      req(0, 0, a + 192);
      chk_flag("hit", 1'b1, RSP_HIT);
      chk_data("half", pat(a + 192), RSP_DATA[HALF_BITS-1:0]);
      idle(12);
    end
    stream(32'h0d000400, 1'b0);
    cancel_en = 1'b1;
    stream(32'h02000300, 1'b1);
    req(0, 0, 32'h02000380);
    chk_flag("miss", 1'b1, RSP_MISS);
    idle(2);
    idle(30);
    cancel_en = 1'b0;
    L2_ACTIVE = 1'b0;
    stream(32'h02004000, 1'b1);
    req(0, 1, 32'h02004080);
    chk_flag("hit", 1'b1, RSP_HIT);
    chk_flag("line", 1'b0, RSP_LINE);
    chk_data("half", pat(32'h02004080), RSP_DATA[HALF_BITS-1:0]);
    idle(2);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    close_out();
  end
endmodule : testbench
